// File: rtl/power_irq_unit.sv
// two-level interrupt unit with an axi4-lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "irq_unit_params.svh"
module power_irq_unit (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [`ADDR_W-1:0]    awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  // axi4-lite write data and response
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [`ADDR_W-1:0]    araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // event sense signals, asynchronous
  input  wire logic [`EV_W-1:0]      sense_in,
  // interrupt outputs
  output logic                       irq_out_n,
  output logic                       sys_irq
);
  import irq_unit_pkg::*;

  localparam int TEST_LAST = `TEST_PULSE_CYC - 1;

  // fixed ten-group map, decoded once for reads and once for writes
  function automatic reg_dec_t dec_addr(input logic [`ADDR_W-1:0] a);
    reg_dec_t d;
    d.sel = SEL_NONE;
    d.grp = 4'h0;
    if (a[11:8] == 4'h0 && a[1:0] == 2'h0) begin
      case (a[7:0])
        `OFF_SYS:  d.sel = SEL_SYS;
        `OFF_TEST: d.sel = SEL_TEST;
        `OFF_IST:  d.sel = SEL_IST;
        `OFF_IMSK: d.sel = SEL_IMSK;
        default: begin
          if (a[7:4] >= `GRP_BASE_IDX && a[7:4] < `GRP_END_IDX) begin
            d.grp = a[7:4] - `GRP_BASE_IDX;
            case (a[3:0])
              `SUB_STAT:  d.sel = SEL_GSTAT;
              `SUB_MASK:  d.sel = SEL_GMASK;
              `SUB_SENSE: d.sel = SEL_GSENSE;
              default:    d.sel = SEL_NONE;
            endcase
          end
        end
      endcase
    end
    return d;
  endfunction

  // axi state
  logic                   awready_r;
  logic                   wready_r;
  logic                   aw_have_r;
  logic                   w_have_r;
  logic [`ADDR_W-1:0]     awaddr_r;
  logic [`GRP_W-1:0]      wdata_r;
  logic                   wstrb0_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   arready_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;
  logic                   do_wr;
  logic                   ar_take;
  reg_dec_t               wr_dec;
  reg_dec_t               ar_dec;
  logic [31:0]            rd_word;

  // block state
  logic [`EV_W-1:0]       sense_s1_r;
  logic [`EV_W-1:0]       sense_s2_r;
  logic [`EV_W-1:0]       sense_s3_r;
  logic [`EV_W-1:0]       sense_rise;
  grp_view_t              view [`NUM_GRP];
  grp_wr_t                grp_wr [`NUM_GRP];
  logic [`NUM_GRP-1:0]    pend_vec;
  logic [`NUM_GRP-1:0]    sys_r;
  logic                   irq_out_n_r;
  logic                   test_act_r;
  logic [`TEST_CNT_W-1:0] test_cnt_r;
  logic                   any_pend_d_r;
  logic [`IST_W-1:0]      ist_r;
  logic [`IST_W-1:0]      ist_ev;
  logic [`IST_W-1:0]      ist_clr;
  logic [`IST_W-1:0]      imsk_r;
  logic                   sys_irq_r;
  logic                   test_go;

  assign wr_dec  = dec_addr(awaddr_r);
  assign ar_dec  = dec_addr(araddr);
  assign do_wr   = aw_have_r && w_have_r;
  assign ar_take = arvalid && arready_r;

  // write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r  <= {`ADDR_W{1'b0}};
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r  <= {`GRP_W{1'b0}};
      wstrb0_r <= 1'b0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r  <= wdata[`GRP_W-1:0];
      wstrb0_r <= wstrb[0];
    end else if (do_wr) begin
      w_have_r <= 1'b0;
    end else if (bvalid_r && bready) begin
      wready_r <= 1'b1;
    end
  end

  // readonly targets answer okay and ignore the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_dec.sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bvalid_r && bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // sense words show the synchronised live level
  always_comb begin
    rd_word = 32'h0000_0000;
    case (ar_dec.sel)
      SEL_SYS:    rd_word[`NUM_GRP-1:0] = sys_r;
      SEL_TEST:   rd_word[0] = test_act_r;
      SEL_IST:    rd_word[`IST_W-1:0] = ist_r;
      SEL_IMSK:   rd_word[`IST_W-1:0] = imsk_r;
      SEL_GSTAT:  rd_word[`GRP_W-1:0] = view[ar_dec.grp].status;
      SEL_GMASK:  rd_word[`GRP_W-1:0] = view[ar_dec.grp].mask;
      SEL_GSENSE: rd_word[`GRP_W-1:0] = view[ar_dec.grp].sense;
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= (ar_dec.sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // two stages before any logic; edges compare the second stage with a third stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_s1_r <= {`EV_W{1'b0}};
      sense_s2_r <= {`EV_W{1'b0}};
      sense_s3_r <= {`EV_W{1'b0}};
    end else begin
      sense_s1_r <= sense_in;
      sense_s2_r <= sense_s1_r;
      sense_s3_r <= sense_s2_r;
    end
  end

  assign sense_rise = sense_s2_r & ~sense_s3_r;

  // groups 0-3 global, 4-6 regulator faults, 7-9 ldo faults
  for (genvar g = 0; g < `NUM_GRP; g++) begin : grp_gen
    assign grp_wr[g].data    = wdata_r;
    assign grp_wr[g].stat_we = do_wr && wstrb0_r && wr_dec.sel == SEL_GSTAT && wr_dec.grp == 4'(g);
    assign grp_wr[g].mask_we = do_wr && wstrb0_r && wr_dec.sel == SEL_GMASK && wr_dec.grp == 4'(g);
    event_latch_group u_grp (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .sense_lvl  (sense_s2_r[g*`GRP_W +: `GRP_W]),
      .sense_rise (sense_rise[g*`GRP_W +: `GRP_W]),
      .wr         (grp_wr[g]),
      .view       (view[g]),
      .pending    (pend_vec[g])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_r <= {`NUM_GRP{1'b0}};
    end else begin
      sys_r <= pend_vec;
    end
  end

  // test pulse; a request during a running pulse is dropped
  assign test_go = do_wr && wstrb0_r && wr_dec.sel == SEL_TEST && wdata_r[0] && !test_act_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_act_r <= 1'b0;
      test_cnt_r <= {`TEST_CNT_W{1'b0}};
    end else if (test_go) begin
      test_act_r <= 1'b1;
      test_cnt_r <= {`TEST_CNT_W{1'b0}};
    end else if (test_act_r) begin
      if (test_cnt_r == `TEST_CNT_W'(TEST_LAST)) begin
        test_act_r <= 1'b0;
      end else begin
        test_cnt_r <= test_cnt_r + 1'b1;
      end
    end
  end

  // pin is low while anything unmasked waits or the test runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out_n_r <= 1'b1;
    end else begin
      irq_out_n_r <= ~((|pend_vec) | test_act_r);
    end
  end

  // block-level status: new pending rise and test end; cleared by reading
  assign ist_ev[`IST_NEW_PEND]  = (|pend_vec) && !any_pend_d_r;
  assign ist_ev[`IST_TEST_DONE] = test_act_r && test_cnt_r == `TEST_CNT_W'(TEST_LAST);
  assign ist_clr = (ar_take && ar_dec.sel == SEL_IST) ? {`IST_W{1'b1}} : {`IST_W{1'b0}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      any_pend_d_r <= 1'b0;
      ist_r        <= {`IST_W{1'b0}};
      sys_irq_r    <= 1'b0;
    end else begin
      any_pend_d_r <= |pend_vec;
      ist_r        <= (ist_r & ~ist_clr) | ist_ev;
      sys_irq_r    <= |(ist_r & ~imsk_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imsk_r <= `IMSK_RST;
    end else if (do_wr && wstrb0_r && wr_dec.sel == SEL_IMSK) begin
      imsk_r <= wdata_r[`IST_W-1:0];
    end
  end

  assign awready   = awready_r;
  assign wready    = wready_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign arready   = arready_r;
  assign rvalid    = rvalid_r;
  assign rdata     = rdata_r;
  assign rresp     = rresp_r;
  assign irq_out_n = irq_out_n_r;
  assign sys_irq   = sys_irq_r;

  // checks
  logic [`GRP_W-1:0] ast_sense;
  assign ast_sense = view[ar_dec.grp].sense;

  // rebuilt from the group views, so the summary checks do not lean on pend_vec
  logic [`NUM_GRP-1:0] ast_pend;
  always_comb begin
    for (int i = 0; i < `NUM_GRP; i++) begin
      ast_pend[i] = |(view[i].status & ~view[i].mask);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_test_req;
    test_go;
  endsequence
  sequence s_pin_follows;
    test_act_r ##1 !irq_out_n_r;
  endsequence
  sequence s_both_taken;
    aw_have_r && w_have_r;
  endsequence

  AST_SYS_FLAG: assert property (1'b1 |=> sys_r == $past(ast_pend))
    else $error("system flags do not follow pending groups");
  AST_MASKED_HIDDEN: assert property ((ast_pend == 10'h000) |=> (sys_r == 10'h000))
    else $error("system flag set without unmasked event");
  AST_IRQ_LOW: assert property ((ast_pend != 10'h000) |=> !irq_out_n_r)
    else $error("interrupt pin not low with pending event");
  AST_IRQ_RELEASE: assert property ((ast_pend == 10'h000 && !test_act_r) |=> irq_out_n_r)
    else $error("interrupt pin low with nothing pending");
  AST_TEST_START: assert property (s_test_req |=> s_pin_follows)
    else $error("test request gave no pulse");
  AST_TEST_LEN: assert property ($fell(test_act_r) |-> ($past(test_cnt_r) == TEST_LAST))
    else $error("test pulse has wrong length");
  AST_RD_SENSE: assert property ((ar_take && ar_dec.sel == SEL_GSENSE) |=> rvalid_r && rdata_r[7:0] == $past(ast_sense))
    else $error("sense read does not show live level");
  AST_WR_RESP: assert property (s_both_taken |=> bvalid_r ##0 !aw_have_r)
    else $error("write not answered after both beats");
endmodule

// File: rtl/irq_unit_params.svh
// offsets, field positions, reset values and timing counts of the interrupt unit
`ifndef IRQ_UNIT_PARAMS_SVH
`define IRQ_UNIT_PARAMS_SVH

`define ADDR_W        12
`define GRP_W         8
`define NUM_GRP       10
`define NUM_GLOBAL    4
`define NUM_SW_FLT    3
`define NUM_LDO_FLT   3
`define EV_W          80
`define IST_W         2

`define OFF_SYS       8'h00
`define OFF_TEST      8'h04
`define OFF_IST       8'h08
`define OFF_IMSK      8'h0c
`define GRP_BASE_IDX  4'h4
`define GRP_END_IDX   4'he
`define SUB_STAT      4'h0
`define SUB_MASK      4'h4
`define SUB_SENSE     4'h8

`define IST_NEW_PEND  0
`define IST_TEST_DONE 1

`define MASK_RST      8'h00
`define IMSK_RST      2'h0
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`define CLK_PERIOD_NS 100
`define TEST_PULSE_NS 100000
`define TEST_PULSE_CYC (`TEST_PULSE_NS / `CLK_PERIOD_NS)
`define TEST_CNT_W    10

`endif

// File: rtl/irq_unit_pkg.sv
// types shared by the interrupt unit files
`include "irq_unit_params.svh"
package irq_unit_pkg;
  typedef enum logic [2:0] {
    SEL_SYS    = 3'b000,
    SEL_TEST   = 3'b001,
    SEL_IST    = 3'b010,
    SEL_IMSK   = 3'b011,
    SEL_GSTAT  = 3'b100,
    SEL_GMASK  = 3'b101,
    SEL_GSENSE = 3'b110,
    SEL_NONE   = 3'b111
  } reg_sel_t;

  typedef struct packed {
    reg_sel_t   sel;
    logic [3:0] grp;
  } reg_dec_t;

  typedef struct packed {
    logic [`GRP_W-1:0] status;
    logic [`GRP_W-1:0] mask;
    logic [`GRP_W-1:0] sense;
  } grp_view_t;

  typedef struct packed {
    logic [`GRP_W-1:0] data;
    logic              stat_we;
    logic              mask_we;
  } grp_wr_t;
endpackage

// File: rtl/event_latch_group.sv
// one second-level group: status latches, mask bits and live sense levels
`timescale 1ns/1ps
`include "irq_unit_params.svh"
module event_latch_group (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // synchronised sense levels and their rising edges
  input  wire logic [`GRP_W-1:0]       sense_lvl,
  input  wire logic [`GRP_W-1:0]       sense_rise,
  // register access
  input  wire irq_unit_pkg::grp_wr_t   wr,
  output irq_unit_pkg::grp_view_t      view,
  output logic                         pending
);
  import irq_unit_pkg::*;

  logic [`GRP_W-1:0] status_r;
  logic [`GRP_W-1:0] mask_r;
  logic [`GRP_W-1:0] clr_h;
  logic [`GRP_W-1:0] keep_h;

  assign clr_h  = wr.stat_we ? wr.data : {`GRP_W{1'b0}};
  assign keep_h = status_r & ~wr.data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= {`GRP_W{1'b0}};
    end else begin
      status_r <= (status_r & ~clr_h) | sense_rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `MASK_RST;
    end else if (wr.mask_we) begin
      mask_r <= wr.data;
    end
  end

  assign view.status = status_r;
  assign view.mask   = mask_r;
  assign view.sense  = sense_lvl;
  assign pending     = |(status_r & ~mask_r);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CLR_ONE: assert property (wr.stat_we |=> ((status_r & $past(clr_h) & ~$past(sense_rise)) == 8'h00))
    else $error("written one did not clear its latch");
  AST_KEEP_ZERO: assert property (wr.stat_we |=> ((status_r & $past(keep_h)) == $past(keep_h)))
    else $error("written zero disturbed a latch");
  AST_SET_WINS: assert property ((|sense_rise) |=> ((status_r & $past(sense_rise)) == $past(sense_rise)))
    else $error("event lost its latch");
  AST_MASK_BLOCK: assert property ((mask_r == 8'hff) |-> !pending)
    else $error("fully masked group reports pending");
endmodule

// File: sim/irq_line_monitor.sv
// host-side watcher of the interrupt line: measures the length of each low pulse
`timescale 1ns/1ps
module irq_line_monitor (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // observed line
  input  wire logic        irq_out_n,
  output logic      [15:0] low_len
);
  logic [15:0] run_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r   <= 16'h0;
      low_len <= 16'h0;
    end else if (irq_out_n == 1'b0) begin
      run_r <= run_r + 16'h1;
    end else if (run_r != 16'h0) begin
      low_len <= run_r;
      run_r   <= 16'h0;
    end
  end
endmodule

// File: sim/power_irq_unit_tb_top.sv
// self-checking bench for the two-level interrupt unit
`timescale 1ns/1ps
`include "irq_unit_params.svh"
module power_irq_unit_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq_out_n, sys_irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [79:0] sense_in;
  logic [15:0] low_len;
  int          fails, samples_checked;

  power_irq_unit DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sense_in(sense_in), .irq_out_n(irq_out_n), .sys_irq(sys_irq));
  irq_line_monitor mon (.aclk(aclk), .aresetn(aresetn), .irq_out_n(irq_out_n), .low_len(low_len));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic final_report();
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    chk(rd, exp);
  endtask

  function automatic logic [11:0] grp(input int g, input logic [3:0] sub);
    return 12'h040 + 12'(g * 16) + {8'h00, sub};
  endfunction

  task automatic t_reset();
    chk(irq_out_n, 1'b1);
    rd_chk(`OFF_SYS, 32'h0);
    rd_chk(grp(0, `SUB_MASK), 32'h0);
    rd_chk(grp(9, `SUB_STAT), 32'h0);
  endtask

  task automatic t_event();
    sense_in[34] <= 1'b1;
    cyc(6);
    rd_chk(grp(4, `SUB_SENSE), 32'h4);
    rd_chk(grp(4, `SUB_STAT), 32'h4);
    rd_chk(`OFF_SYS, 32'h10);
    chk(irq_out_n, 1'b0);
    chk(sys_irq, 1'b1);
    rd_chk(`OFF_IST, 32'h1);
    rd_chk(`OFF_IST, 32'h0);
    sense_in[34] <= 1'b0;
    cyc(4);
    rd_chk(grp(4, `SUB_SENSE), 32'h0);
    rd_chk(grp(4, `SUB_STAT), 32'h4);
    axi_wr(grp(4, `SUB_STAT), 32'h0, rs);
    rd_chk(grp(4, `SUB_STAT), 32'h4);
    axi_wr(grp(4, `SUB_STAT), 32'h4, rs);
    rd_chk(grp(4, `SUB_STAT), 32'h0);
    cyc(2);
    chk(irq_out_n, 1'b1);
    rd_chk(`OFF_SYS, 32'h0);
  endtask

  task automatic t_mask();
    axi_wr(grp(8, `SUB_MASK), 32'h2, rs);
    rd_chk(grp(8, `SUB_MASK), 32'h2);
    axi_wr(`OFF_IMSK, 32'h3, rs);
    rd_chk(`OFF_IMSK, 32'h3);
    sense_in[65] <= 1'b1;
    cyc(6);
    rd_chk(grp(8, `SUB_STAT), 32'h2);
    rd_chk(`OFF_SYS, 32'h0);
    chk(irq_out_n, 1'b1);
    axi_wr(grp(8, `SUB_MASK), 32'h0, rs);
    cyc(2);
    rd_chk(`OFF_SYS, 32'h100);
    chk(irq_out_n, 1'b0);
    // block mask holds the summary output quiet while the status bit is set
    chk(sys_irq, 1'b0);
    rd_chk(`OFF_IST, 32'h1);
    sense_in[65] <= 1'b0;
    axi_wr(grp(8, `SUB_STAT), 32'h2, rs);
    axi_wr(`OFF_IMSK, 32'h0, rs);
    cyc(2);
  endtask

  task automatic t_groups();
    for (int g = 0; g < 10; g++) begin
      sense_in[g * 8 + (g % 8)] <= 1'b1;
      cyc(6);
      rd_chk(`OFF_SYS, 32'h1 << g);
      rd_chk(grp(g, `SUB_STAT), 32'h1 << (g % 8));
      sense_in[g * 8 + (g % 8)] <= 1'b0;
      axi_wr(grp(g, `SUB_STAT), 32'h1 << (g % 8), rs);
      cyc(2);
    end
    rd_chk(`OFF_IST, 32'h1);
  endtask

  task automatic t_unmapped();
    axi_rd(12'h100, rd, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    chk(rd, 32'h0);
    axi_wr(12'h0f0, 32'hff, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    // lane 0 off: the write is answered but leaves the mask alone
    wstrb <= 4'h0;
    axi_wr(grp(3, `SUB_MASK), 32'hff, rs);
    wstrb <= 4'hf;
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
    rd_chk(grp(3, `SUB_MASK), 32'h0);
  endtask

  task automatic t_test();
    int t;
    axi_wr(`OFF_TEST, 32'h1, rs);
    cyc(3);
    rd_chk(`OFF_TEST, 32'h1);
    chk(irq_out_n, 1'b0);
    t = 0;
    // bounded wait for the pulse to end
    while (irq_out_n !== 1'b1 && t < 1200) begin
      @(posedge aclk);
      t++;
    end
    cyc(2);
    chk({16'h0, low_len}, 32'(`TEST_PULSE_CYC));
    rd_chk(`OFF_IST, 32'h2);
  endtask

  initial begin
    aresetn  = 1'b0;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    awaddr   = 12'h0;
    araddr   = 12'h0;
    wdata    = 32'h0;
    wstrb    = 4'hf;
    sense_in = 80'h0;
    fails    = 0;
    samples_checked = 0;
    cyc(3);
    aresetn <= 1'b1;
    t_reset();
    t_event();
    t_mask();
    t_groups();
    t_unmapped();
    t_test();
    final_report();
  end

  // run needs about 1300 cycles; over twenty times that means a hang
  initial begin
    #3000000;
    fails++;
    final_report();
  end
endmodule
